//--- shared/tcc_pkg.sv
// Shared constants and carrier types for the trigger and capture controller.
// Assumes a single 50 MHz clock domain; all users import the whole package.
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and sample timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BASE_HZ = 10_000;
  localparam int TICK_CYC_DEF = CLK_HZ / BASE_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // Widths, depth and divider range
  localparam int DW = 16;
  localparam int DEPTH = 16384;
  localparam int AW = 14;
  localparam int CW = 15;
  localparam int NTRIG = 8;
  localparam logic [CW-1:0] DIV_MAX = 15'h4000;
  localparam logic [CW-1:0] CNT_FULL = 15'h4000;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source codes
  localparam logic [3:0] SRC_FRONT = 4'h0;
  localparam logic [3:0] SRC_SW = 4'h1;
  localparam logic [3:0] SRC_PXI0 = 4'h2;
  localparam logic [3:0] SRC_PXI7 = 4'h9;
  localparam logic [3:0] SRC_STAR = 4'hA;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [3:0] src;
    logic falling;
    logic upd_en;
    logic cap_en;
    logic cap_current;
    logic trig_clk;
    logic [CW-1:0] div;
  } tcc_cfg_t;

  typedef struct packed {
    logic [DW-1:0] volt;
    logic [DW-1:0] curr;
  } tcc_sp_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_CAPT,
    ST_READ
  } tcc_state_t;

endpackage

//--- rtl/tcc_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs are unrelated to clk; output is a clean level on clk.
`timescale 1ns/1ps
module tcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins and filtered levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } tcc_sync_st_t;

  tcc_sync_st_t r;
  tcc_sync_st_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds stage two only; a bit changes once stages two and three agree
  always_comb begin
    next_r = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.lvl[i] = r.s3[i];
      end
    end
  end

  // Register the whole state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.lvl;

endmodule

//--- rtl/tcc_top.sv
// Trigger selection, edge detection, setpoint update and transient capture.
// Assumes config, commands and measurements arrive synchronous to clk;
// trigger pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module tcc_top
  import tcc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Trigger pins
  input wire logic front_trig_in,
  input wire logic [NTRIG-1:0] pxi_trig_in,
  input wire logic pxi_star_in,
  // Configuration and commands
  input wire tcc_cfg_t cfg,
  input wire logic arm_cmd,
  input wire logic disarm_cmd,
  input wire logic sw_trig_cmd,
  input wire logic readout_cmd,
  // Setpoint programming
  input wire logic set_wr,
  input wire logic set_ch,
  input wire tcc_sp_t set_sp,
  input wire logic pend_wr,
  input wire logic pend_ch,
  input wire tcc_sp_t pend_sp,
  // Measurements from the converters
  input wire tcc_sp_t [1:0] meas,
  // Host memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_ch,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [DW-1:0] mem_wdata,
  // Channel setpoints and status
  output tcc_sp_t [1:0] act_sp,
  output logic armed,
  output logic capturing,
  output logic readback_en,
  output logic triggered,
  output logic [CW-1:0] sample_count,
  // Memory answers
  output logic out_valid,
  output logic out_ch,
  output logic out_stream,
  output logic out_last,
  output logic [DW-1:0] out_data
);

  typedef struct packed {
    tcc_state_t state;
    tcc_sp_t [1:0] pend;
    tcc_sp_t [1:0] act;
    logic prev;
    logic [15:0] base_cnt;
    logic [CW-1:0] div_cnt;
    logic [CW-1:0] count;
    logic triggered;
    logic [CW-1:0] rd_idx;
    logic rd_ch;
    logic rvalid;
    logic rch;
    logic rstream;
    logic rlast;
    logic is_armed;
    logic is_capt;
    logic rb_on;
  } tcc_st_t;

  tcc_st_t r;
  tcc_st_t next_r;

  logic [NTRIG-1:0] pxi_lvl;
  logic front_lvl;
  logic star_lvl;
  logic sel_lvl;
  logic trig;
  logic base_tick;
  logic samp_tick;
  logic take;
  logic [CW-1:0] div_eff;
  logic wr_en0;
  logic wr_en1;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_d0;
  logic [DW-1:0] wr_d1;
  logic rd_go;
  logic rd_sel;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  logic [DW-1:0] mem0 [DEPTH];
  logic [DW-1:0] mem1 [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; one instance covers all ten trigger pins
  tcc_sync #(
    .W(NTRIG + 2)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({pxi_star_in, front_trig_in, pxi_trig_in}),
    .level({star_lvl, front_lvl, pxi_lvl})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source select and edge detect
  always_comb begin
    sel_lvl = 1'b0;
    if (cfg.src == SRC_FRONT) begin
      sel_lvl = front_lvl;
    end else if (cfg.src == SRC_STAR) begin
      sel_lvl = star_lvl;
    end else if (cfg.src >= SRC_PXI0 && cfg.src <= SRC_PXI7) begin
      sel_lvl = pxi_lvl[3'(cfg.src - SRC_PXI0)];
    end
    // Software source bypasses the pins; the command level is the trigger, taken each cycle it is high with no edge detect
    if (cfg.src == SRC_SW) begin
      trig = sw_trig_cmd;
    end else if (cfg.falling) begin
      trig = r.prev & ~sel_lvl;
    end else begin
      trig = ~r.prev & sel_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock: 10 kHz base enable, then divide by N (0 treated as 1)
  always_comb begin
    div_eff = (cfg.div == '0) ? 15'h0001 : cfg.div;
    if (div_eff > DIV_MAX) begin
      div_eff = DIV_MAX;
    end
    base_tick = (r.base_cnt == 16'(TICK_CYC - 1));
    samp_tick = base_tick && (r.div_cnt == div_eff - 15'h0001);
    take = cfg.trig_clk ? trig : samp_tick;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main control: state, setpoints, counters, memory port requests
  always_comb begin
    next_r = r;
    next_r.prev = sel_lvl;
    next_r.rvalid = 1'b0;
    next_r.rlast = 1'b0;
    wr_en0 = 1'b0;
    wr_en1 = 1'b0;
    wr_addr = r.count[AW-1:0];
    wr_d0 = cfg.cap_current ? meas[0].curr : meas[0].volt;
    wr_d1 = cfg.cap_current ? meas[1].curr : meas[1].volt;
    rd_go = 1'b0;
    rd_sel = r.rd_ch;
    rd_addr = r.rd_idx[AW-1:0];

    // Pending values may be loaded at any time
    if (pend_wr) begin
      next_r.pend[pend_ch] = pend_sp;
    end

    case (r.state)
      ST_IDLE: begin
        // Direct setpoints are only honoured while not armed
        if (set_wr) begin
          next_r.act[set_ch] = set_sp;
        end
        if (arm_cmd) begin
          next_r.state = ST_WAIT;
          next_r.count = '0;
          next_r.triggered = 1'b0;
        end else if (readout_cmd) begin
          next_r.rd_idx = '0;
          next_r.rd_ch = 1'b0;
          if (r.count != '0) begin
            next_r.state = ST_READ;
          end
        end else if (mem_req) begin
          // Diagnostic access; refused while armed or streaming
          if (mem_we) begin
            wr_en0 = ~mem_ch;
            wr_en1 = mem_ch;
            wr_addr = mem_addr;
            wr_d0 = mem_wdata;
            wr_d1 = mem_wdata;
          end else begin
            rd_go = 1'b1;
            rd_sel = mem_ch;
            rd_addr = mem_addr;
            next_r.rvalid = 1'b1;
            next_r.rch = mem_ch;
            next_r.rstream = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (disarm_cmd) begin
          next_r.state = ST_IDLE;
        end else if (trig) begin
          next_r.triggered = 1'b1;
          if (cfg.upd_en) begin
            next_r.act = r.pend;
          end
          next_r.base_cnt = '0;
          next_r.div_cnt = '0;
          if (cfg.cap_en) begin
            next_r.state = ST_CAPT;
            // Trigger-as-clock: the arming trigger itself is the first sample
            if (cfg.trig_clk) begin
              wr_en0 = 1'b1;
              wr_en1 = 1'b1;
              next_r.count = 15'h0001;
            end
          end else begin
            next_r.state = ST_IDLE;
          end
        end
      end
      ST_CAPT: begin
        next_r.base_cnt = base_tick ? '0 : r.base_cnt + 16'h0001;
        if (base_tick) begin
          next_r.div_cnt = samp_tick ? '0 : r.div_cnt + 15'h0001;
        end
        if (disarm_cmd) begin
          next_r.state = ST_IDLE;
        end else if (r.count == CNT_FULL) begin
          next_r.state = ST_IDLE;
        end else if (take) begin
          // Count never passes the depth, so no write lands beyond it
          wr_en0 = 1'b1;
          wr_en1 = 1'b1;
          next_r.count = r.count + 15'h0001;
          if (r.count + 15'h0001 == CNT_FULL) begin
            next_r.state = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        // Channel 0 then channel 1 for each index, oldest first
        rd_go = 1'b1;
        next_r.rvalid = 1'b1;
        next_r.rch = r.rd_ch;
        next_r.rstream = 1'b1;
        next_r.rd_ch = ~r.rd_ch;
        if (r.rd_ch) begin
          next_r.rd_idx = r.rd_idx + 15'h0001;
          if (r.rd_idx + 15'h0001 == r.count) begin
            next_r.rlast = 1'b1;
            next_r.state = ST_IDLE;
          end
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // Status flags follow the next state, so each status output leaves a flop
    next_r.is_armed = (next_r.state == ST_WAIT) || (next_r.state == ST_CAPT);
    next_r.is_capt = (next_r.state == ST_CAPT);
    next_r.rb_on = !next_r.is_armed;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; readback is live out of reset since nothing is armed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
      r.rb_on <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture memory; no reset so it maps onto block RAM
  always_ff @(posedge clk) begin
    if (wr_en0) begin
      mem0[wr_addr] <= wr_d0;
    end
    if (wr_en1) begin
      mem1[wr_addr] <= wr_d1;
    end
    if (rd_go) begin
      rd_data <= rd_sel ? mem1[rd_addr] : mem0[rd_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops: state flops, and out_data from the memory read register
  assign act_sp = r.act;
  assign armed = r.is_armed;
  assign capturing = r.is_capt;
  assign readback_en = r.rb_on;
  assign triggered = r.triggered;
  assign sample_count = r.count;
  assign out_valid = r.rvalid;
  assign out_ch = r.rch;
  assign out_stream = r.rstream;
  assign out_last = r.rlast;
  assign out_data = rd_data;

endmodule

//--- test/tcc_props.sv
// Port-level checker for the trigger and capture controller.
// Assumes it is bound into tcc_top; one clock, sync active-low reset.
`timescale 1ns/1ps
module tcc_props
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Inputs and status watched
  input wire logic disarm_cmd,
  input wire logic set_wr,
  input wire tcc_sp_t [1:0] act_sp,
  input wire logic armed,
  input wire logic capturing,
  input wire logic readback_en,
  input wire logic triggered,
  input wire logic [CW-1:0] sample_count,
  input wire logic out_valid,
  input wire logic out_stream,
  input wire logic out_last
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Arming, disarming and suspension
  arm_clear_a: assert property ($rose(armed) |-> sample_count == '0 && !triggered)
    else $error("count or flag not cleared at arm");
  disarm_now_a: assert property (armed && disarm_cmd |=> !armed)
    else $error("disarm not taken");
  readback_off_a: assert property (readback_en == !armed)
    else $error("readback not tied to armed");
  sp_hold_a: assert property (armed && set_wr |=> $stable(act_sp) || $rose(triggered))
    else $error("direct setpoint taken while armed");
  trig_armed_a: assert property ($rose(triggered) |-> $past(armed))
    else $error("trigger accepted while not armed");
  // Capture progress and readout; a jump of more than one would skip memory
  full_stop_a: assert property (sample_count == CNT_FULL |-> !armed)
    else $error("still armed with full count");
  count_step_a: assert property (capturing |=> sample_count - $past(sample_count) <= 15'h0001)
    else $error("count stepped by more than one");
  capt_state_a: assert property (capturing |-> armed && triggered)
    else $error("capturing without trigger");
  last_word_a: assert property (out_last |-> out_valid && out_stream)
    else $error("last flag outside stream");
endmodule

//--- test/tcc_trig_model.sv
// Behavioural driver of the front, backplane and star trigger pins.
// Assumes the bench calls set_pin just after a falling clock edge.
`timescale 1ns/1ps
module tcc_trig_model
  import tcc_pkg::*;
(
  // Trigger pins toward the block
  output logic front,
  output logic [NTRIG-1:0] line,
  output logic star
);
  // Lines rest high through their pull-ups
  initial begin
    front = 1'b1;
    line = 8'hFF;
    star = 1'b1;
  end
  // Pin 0 front, 1..8 backplane lines, 9 star; levels are unrelated to clk
  task automatic set_pin(input int s, input logic v);
    if (s == 0) front = v;
    else if (s == 9) star = v;
    else line[s-1] = v;
  endtask
endmodule

//--- test/tcc_top_tb.sv
// Self-checking bench for the trigger and capture controller.
// Assumes a 50 MHz clock; TICK_CYC is cut to 5 to keep runs short.
`timescale 1ns/1ps
module tcc_top_tb
  import tcc_pkg::*;
;
  localparam int TK = 5;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic arm = 1'b0, dis = 1'b0, swt = 1'b0, rdo = 1'b0;
  logic set_wr = 1'b0, set_ch = 1'b0, pend_wr = 1'b0, pend_ch = 1'b0;
  logic mem_req = 1'b0, mem_we = 1'b0, mem_ch = 1'b0;
  logic [AW-1:0] mem_addr = '0;
  logic [DW-1:0] mem_wdata = '0;
  tcc_cfg_t cfg = '0;
  tcc_sp_t set_sp = '0, pend_sp = '0;
  tcc_sp_t [1:0] meas = '0, act_sp;
  logic front, star, armed, capturing, readback_en, triggered;
  logic out_valid, out_ch, out_stream, out_last;
  logic [NTRIG-1:0] line;
  logic [CW-1:0] sample_count;
  logic [DW-1:0] out_data;
  int err_count = 0;
  int n_checks = 0;
  ////////////////////////////////////////////////////////////
  // Clock, far side and block
  initial begin
    forever #10 clk = ~clk;
  end
  tcc_trig_model pm (.front(front), .line(line), .star(star));
  tcc_top #(.TICK_CYC(TK)) dut (.clk(clk), .resetn(resetn), .front_trig_in(front),
    .pxi_trig_in(line), .pxi_star_in(star), .cfg(cfg), .arm_cmd(arm), .disarm_cmd(dis),
    .sw_trig_cmd(swt), .readout_cmd(rdo), .set_wr(set_wr), .set_ch(set_ch), .set_sp(set_sp),
    .pend_wr(pend_wr), .pend_ch(pend_ch), .pend_sp(pend_sp), .meas(meas), .mem_req(mem_req),
    .mem_we(mem_we), .mem_ch(mem_ch), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .act_sp(act_sp), .armed(armed), .capturing(capturing), .readback_en(readback_en),
    .triggered(triggered), .sample_count(sample_count), .out_valid(out_valid),
    .out_ch(out_ch), .out_stream(out_stream), .out_last(out_last), .out_data(out_data));
  ////////////////////////////////////////////////////////////
  // Shared tasks; inputs change only at falling edges
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One-cycle command pulse: 0 arm, 1 disarm, 2 software trigger, 3 readout
  task automatic cmd(input int k);
    case (k)
      0: arm = 1'b1;
      1: dis = 1'b1;
      2: swt = 1'b1;
      default: rdo = 1'b1;
    endcase
    cyc(1);
    // Drop only the strobe raised, so the next command may raise another here
    case (k)
      0: arm = 1'b0;
      1: dis = 1'b0;
      2: swt = 1'b0;
      default: rdo = 1'b0;
    endcase
  endtask
  task automatic wr_sp(input logic p, input logic ch, input tcc_sp_t v);
    {pend_ch, set_ch, pend_sp, set_sp} = {ch, ch, v, v};
    {pend_wr, set_wr} = {p, !p};
    cyc(1);
    {pend_wr, set_wr} = 2'h0;
    // Idle cycle so a following call never lowers and raises a strobe together
    cyc(1);
  endtask
  // Request is left up; the caller drops it, so back-to-back calls are clean
  task automatic mem(input logic we, input logic ch, input logic [15:0] d);
    {mem_req, mem_we, mem_ch, mem_addr, mem_wdata} = {1'b1, we, ch, 14'h3FFF, d};
    cyc(1);
    if (!we) begin
      chk("mem vld", 1'b1, out_valid);
      chk("mem data", {out_stream, out_ch, d}, {out_stream, out_ch, out_data});
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_upd;
    cfg = '0;
    cfg.src = SRC_SW;
    cfg.upd_en = 1'b1;
    chk("rst arm", 1'b0, armed);
    wr_sp(1'b1, 1'b0, 32'h1234_5678);
    wr_sp(1'b1, 1'b1, 32'h9ABC_DEF0);
    wr_sp(1'b0, 1'b0, 32'h0011_0022);
    chk("act0", 32'h0011_0022, act_sp[0]);
    cmd(2);
    chk("idle trg", 1'b0, triggered);
    cmd(0);
    chk("rb off", 1'b0, readback_en);
    wr_sp(1'b0, 1'b0, 32'h0);
    chk("act0 hold", 32'h0011_0022, act_sp[0]);
    cmd(2);
    chk("act0 upd", 32'h1234_5678, act_sp[0]);
    chk("act1 upd", 32'h9ABC_DEF0, act_sp[1]);
    chk("sw trg", 1'b1, triggered);
    chk("upd only", 1'b0, armed);
    // Host parks channel 1 at zero volts, current kept, before a connection change
    wr_sp(1'b0, 1'b1, 32'h0000_DEF0);
    chk("zero volt", 32'h0000_DEF0, act_sp[1]);
    $display("t_upd done");
  endtask
  // Every pin source, one polarity each (falling on odd s); the wrong edge must pass unnoticed
  task automatic t_edges;
    for (int s = 0; s < 10; s++) begin
      cfg.src = (s == 0) ? SRC_FRONT : (s == 9) ? SRC_STAR : SRC_PXI0 + 4'(s - 1);
      cfg.falling = s[0];
      pm.set_pin(s, !s[0]);
      cyc(8);
      cmd(0);
      pm.set_pin(s, s[0]);
      cyc(8);
      chk("wrong edge", 1'b0, triggered);
      pm.set_pin(s, !s[0]);
      for (int i = 0; i < 10 && triggered !== 1'b1; i++) cyc(1);
      chk("edge trg", 1'b1, triggered);
      chk("edge arm", 1'b0, armed);
    end
    $display("t_edges done");
  endtask
  task automatic t_tclk;
    cfg = '0;
    cfg.cap_en = 1'b1;
    cfg.cap_current = 1'b1;
    cfg.trig_clk = 1'b1;
    pm.set_pin(0, 1'b0);
    cyc(8);
    cmd(0);
    chk("cnt arm", 1'b0, sample_count);
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 2; c++) meas[c] = {16'hA000 + 16'(2 * k + c), 16'hC000 + 16'(2 * k + c)};
      pm.set_pin(0, 1'b1);
      cyc(8);
      pm.set_pin(0, 1'b0);
      cyc(8);
    end
    chk("cnt", 3, sample_count);
    chk("capt", 1'b1, capturing);
    cmd(1);
    chk("disarm", 1'b0, armed);
    chk("rb on", 1'b1, readback_en);
    cmd(3);
    for (int i = 0; i < 4 && out_valid !== 1'b1; i++) cyc(1);
    for (int w = 0; w < 6; w++) begin
      chk("rd word", {1'b1, 1'(w % 2), w == 5, 16'hC000 + 16'(w)},
        {out_valid, out_ch, out_last, out_data});
      cyc(1);
    end
    chk("rd end", 1'b0, out_valid);
    $display("t_tclk done");
  endtask
  // Internal pacing: one sample every TK*N cycles
  task automatic t_pace;
    cfg.src = SRC_SW;
    cfg.trig_clk = 1'b0;
    cfg.div = 15'h0002;
    cmd(0);
    cmd(2);
    // First sample lands exactly TK*N edges after the trigger edge, then every TK*N
    cyc(9);
    chk("pace0", 0, sample_count);
    cyc(1);
    chk("pace1", 1, sample_count);
    cyc(9);
    chk("pace1 hold", 1, sample_count);
    cyc(1);
    chk("pace2", 2, sample_count);
    cmd(1);
    $display("t_pace done");
  endtask
  task automatic t_full;
    cfg.div = 15'h0001;
    cmd(0);
    cmd(2);
    for (int i = 0; i < 16384 * TK + 50 && armed !== 1'b0; i++) cyc(1);
    chk("full cnt", CNT_FULL, sample_count);
    chk("full rb", 1'b1, readback_en);
    cyc(2 * TK);
    chk("full hold", CNT_FULL, sample_count);
    $display("t_full done");
  endtask
  // Pattern test on both channel memories, then a refused read while armed
  task automatic t_mem;
    mem(1'b1, 1'b1, 16'h5A5A);
    mem(1'b1, 1'b0, 16'hA5A5);
    mem(1'b0, 1'b1, 16'h5A5A);
    mem(1'b0, 1'b0, 16'hA5A5);
    cmd(0);
    cyc(1);
    chk("mem refused", 1'b0, out_valid);
    mem_req = 1'b0;
    cmd(1);
    $display("t_mem done");
  endtask
  ////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    resetn = 1'b1;
    cyc(6);
    t_upd();
    t_edges();
    t_tclk();
    t_pace();
    t_full();
    t_mem();
    summarize();
  end
  // Tests take about 82000 cycles; allow a margin beyond that
  initial begin
    #(20 * 100000);
    err_count++;
    $display("watchdog expired");
    summarize();
  end
endmodule
bind tcc_top tcc_props u_props (.clk, .resetn, .disarm_cmd, .set_wr, .act_sp, .armed, .capturing,
  .readback_en, .triggered, .sample_count, .out_valid, .out_stream, .out_last);
